//--- core/pmcr_pkg.sv
// constants shared by the power-mode and clock-request block
// assumes a 100 MHz bus clock and word-wide register access
package pmcr_pkg;

  // ************************************************************
  // register indices, byte address is four times the index
  // ************************************************************
  localparam logic [13:0] IDX_OSC_REQ = 14'h088D;
  localparam logic [13:0] IDX_PWR_CTRL = 14'h088E;
  localparam logic [13:0] IDX_STATUS = 14'h088F;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int SRC_LSB = 4;
  localparam int SRC_MSB = 6;
  localparam int DIV_LSB = 0;
  localparam int DIV_MSB = 3;
  localparam int PWR_IDLE_BIT = 0;
  localparam int PWR_ROI_BIT = 1;
  localparam int PWR_DOZE_BIT = 2;
  localparam int PWR_REGPM_BIT = 3;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_MODE_LSB = 9;

  // ************************************************************
  // source codes and divider range
  // ************************************************************
  localparam logic [2:0] SRC_EXTERNAL = 3'h7;
  localparam logic [2:0] SRC_FAST_INT = 3'h6;
  localparam logic [2:0] SRC_SLOW_INT = 3'h5;
  localparam logic [2:0] SRC_SECONDARY = 3'h4;
  localparam logic [2:0] SRC_EXT_PLL4 = 3'h2;
  localparam logic [2:0] SRC_FAST_PLL2 = 3'h1;
  localparam logic [3:0] DIV_MIN_CODE = 4'h2;
  localparam logic [3:0] DIV_MAX_CODE = 4'h9;

  // ready vector bit positions
  localparam int RDY_EXTERNAL = 0;
  localparam int RDY_FAST_INT = 1;
  localparam int RDY_SLOW_INT = 2;
  localparam int RDY_SECONDARY = 3;
  localparam int RDY_PLL_LOCK = 4;
  localparam int RDY_WIDTH = 5;

  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic [2:0] RESET_SOURCE = 3'h6;
  localparam logic [3:0] RESET_DIVIDER = 4'h2;
  localparam logic [3:0] RESET_PWR_CTRL = 4'h0;
  localparam int CLK_PERIOD_NS = 10;
  localparam int LP_WAKE_DELAY_NS = 10000;
  // least time, so round up
  localparam int LP_WAKE_CYCLES =
    (LP_WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // htrans codes
  // ************************************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_SLEEP,
    MODE_WAKE
  } pmcr_mode_t;

endpackage

//--- core/pmcr_sync3.sv
// three-stage synchroniser for levels arriving from other domains
// assumes only that its output is sampled in the hclk domain
`timescale 1ns/10ps
`default_nettype none

module pmcr_sync3 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // async level in, filtered level out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire logic [WIDTH-1:0] next_out;

  // stage1 feeds stage2 only; a bit moves once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      assign next_out[g] = (stage2[g] == stage3[g]) ? stage3[g] :
                                                      sync_out[g];
    end
  endgenerate

  // plain shift chain, all cleared at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_out <= next_out;
    end
  end

endmodule

`default_nettype wire

//--- core/pmcr_top.sv
// power-mode and clock-request controller with an AHB-Lite slave
// assumes cpu strobes and interrupt level come from hclk logic and
// oscillator ready flags come from analog blocks on their own clocks
//
// Behaviour
// R1: source field picks external, fast, slow, secondary or pll variants
// R2: divider field picks a power of two ratio, 4 up to 512
// R3: normal sleep keeps regulator normal, wake with no extra delay
// R4: low-power sleep adds a settling delay before execution resumes
// R5: low-power sleep guarantees only a few peripherals to work
// R6: low-voltage variant has no low-power choice, always lowest, no delay
// R7: sleep instruction gives full sleep if idle-select 0, idle if 1
// R8: idle stops the cpu and program memory, peripheral clocks run
// R9: system-clock peripherals run in idle only, internal ones always
// R10: with clock output enabled the clock pin keeps running in idle
// R11: any interrupt ends idle, idle-select bit left unchanged
// R12: recover-on-interrupt with doze returns cpu to full speed; the code clears doze only on an interrupt that ends idle
// R13: a new source or divider applies only once the oscillator is ready
`timescale 1ns/10ps
`default_nettype none

module pmcr_top #(
  parameter bit LOW_VOLTAGE_VARIANT = 1'b0,
  parameter int WAKE_CYCLES = pmcr_pkg::LP_WAKE_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // cpu side
  input wire logic sleep_exec,
  input wire logic interrupt_req,
  input wire logic clock_output_enable_n,
  // oscillator ready flags, asynchronous
  input wire logic [pmcr_pkg::RDY_WIDTH-1:0] osc_ready,
  // clock tree and power controls
  output logic cpu_clock_enable,
  output logic program_memory_enable,
  output logic sysclk_periph_enable,
  output logic intosc_periph_enable,
  output logic clock_output_active,
  output logic regulator_low_power,
  output logic full_speed,
  output logic [2:0] active_source,
  output logic [3:0] active_divider,
  output logic switch_busy
);

  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic addr_hit(input logic [31:0] a,
                                    input logic [13:0] idx);
    addr_hit = (a[31:16] == 16'h0000) && (a[15:2] == idx);
  endfunction

  // ready for the requested source, pll variants also need lock
  function automatic logic src_ready(input logic [2:0] code,
      input logic [pmcr_pkg::RDY_WIDTH-1:0] rdy);
    case (code)
      pmcr_pkg::SRC_EXTERNAL: src_ready = rdy[pmcr_pkg::RDY_EXTERNAL];
      pmcr_pkg::SRC_FAST_INT: src_ready = rdy[pmcr_pkg::RDY_FAST_INT];
      pmcr_pkg::SRC_SLOW_INT: src_ready = rdy[pmcr_pkg::RDY_SLOW_INT];
      pmcr_pkg::SRC_SECONDARY: src_ready = rdy[pmcr_pkg::RDY_SECONDARY];
      pmcr_pkg::SRC_EXT_PLL4: src_ready = rdy[pmcr_pkg::RDY_EXTERNAL] &&
                                          rdy[pmcr_pkg::RDY_PLL_LOCK];
      pmcr_pkg::SRC_FAST_PLL2: src_ready = rdy[pmcr_pkg::RDY_FAST_INT] &&
                                           rdy[pmcr_pkg::RDY_PLL_LOCK];
      default: src_ready = 1'b0;
    endcase
  endfunction

  // reserved codes 011 and 000 are refused
  function automatic logic src_valid(input logic [2:0] code);
    src_valid = (code != 3'h3) && (code != 3'h0); // R1
  endfunction

  // divider codes 0010..1001 give 4..512
  function automatic logic div_valid(input logic [3:0] code);
    div_valid = (code >= pmcr_pkg::DIV_MIN_CODE) &&
                (code <= pmcr_pkg::DIV_MAX_CODE); // R2
  endfunction

  // ************************************************************
  // ready synchroniser
  // ************************************************************
  logic [pmcr_pkg::RDY_WIDTH-1:0] ready_sync;

  pmcr_sync3 #(
    .WIDTH(pmcr_pkg::RDY_WIDTH)
  ) u_ready_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(osc_ready),
    .sync_out(ready_sync)
  );

  // ************************************************************
  // state
  // ************************************************************
  logic wr_pend;
  logic [13:0] wr_idx;
  logic [2:0] req_src;
  logic [3:0] req_div;
  logic idle_select;
  logic recover_on_interrupt;
  logic doze_enable;
  logic regulator_power_mode;
  logic [15:0] wake_cnt;
  pmcr_pkg::pmcr_mode_t mode;

  logic next_wr_pend;
  logic [13:0] next_wr_idx;
  logic [31:0] next_hrdata;
  logic [2:0] next_req_src;
  logic [3:0] next_req_div;
  logic next_idle_select;
  logic next_roi;
  logic next_doze;
  logic next_regpm;
  logic [2:0] next_act_src;
  logic [3:0] next_act_div;
  logic next_busy;
  logic [15:0] next_wake_cnt;
  pmcr_pkg::pmcr_mode_t next_mode;
  logic next_cpu_en;
  logic next_pmem_en;
  logic next_sys_en;
  logic next_clkout;
  logic next_reg_lp;
  logic wr_req;
  logic wr_pwr;

  // ************************************************************
  // control registers, clock switch and power modes
  // ************************************************************
  // one process so read-back, switch and mode see the same write
  always_comb begin
    wr_req = wr_pend && (wr_idx == pmcr_pkg::IDX_OSC_REQ);
    wr_pwr = wr_pend && (wr_idx == pmcr_pkg::IDX_PWR_CTRL);
    next_req_src = req_src;
    next_req_div = req_div;
    next_idle_select = idle_select;
    next_roi = recover_on_interrupt;
    next_doze = doze_enable;
    next_regpm = regulator_power_mode;
    next_act_src = active_source;
    next_act_div = active_divider;
    next_busy = switch_busy;
    next_mode = mode;
    next_wake_cnt = wake_cnt;
    // old clock stays until the target oscillator reports ready
    if (switch_busy && src_ready(req_src, ready_sync)) begin
      next_act_src = req_src; // R13
      next_act_div = req_div; // R13
      next_busy = 1'b0;
    end
    // a write re-arms the switch, so it wins over completion
    if (wr_req) begin
      next_req_src = hwdata[pmcr_pkg::SRC_MSB:pmcr_pkg::SRC_LSB]; // R1
      next_req_div = hwdata[pmcr_pkg::DIV_MSB:pmcr_pkg::DIV_LSB]; // R2
      next_busy = src_valid(next_req_src) && div_valid(next_req_div);
    end
    if (wr_pwr) begin
      next_idle_select = hwdata[pmcr_pkg::PWR_IDLE_BIT];
      next_roi = hwdata[pmcr_pkg::PWR_ROI_BIT];
      next_doze = hwdata[pmcr_pkg::PWR_DOZE_BIT];
      // the low-voltage variant has no selectable low-power sleep
      next_regpm = hwdata[pmcr_pkg::PWR_REGPM_BIT] &&
                   !LOW_VOLTAGE_VARIANT; // R6
    end
    case (mode)
      pmcr_pkg::MODE_RUN: begin
        if (sleep_exec) begin
          next_mode = idle_select ? pmcr_pkg::MODE_IDLE :
                                    pmcr_pkg::MODE_SLEEP; // R7
        end
      end
      pmcr_pkg::MODE_IDLE: begin
        // any interrupt wakes, global enable is not consulted
        if (interrupt_req) begin
          next_mode = pmcr_pkg::MODE_RUN; // R11
          // hardware clear of doze loses to a same-cycle software set
          if (recover_on_interrupt && doze_enable &&
              !(wr_pwr && hwdata[pmcr_pkg::PWR_DOZE_BIT])) begin
            next_doze = 1'b0; // R12
          end
        end
      end
      pmcr_pkg::MODE_SLEEP: begin
        if (interrupt_req) begin
          if (regulator_power_mode && !LOW_VOLTAGE_VARIANT) begin
            next_mode = pmcr_pkg::MODE_WAKE; // R4
            next_wake_cnt = 16'(WAKE_CYCLES - 1);
          end else begin
            next_mode = pmcr_pkg::MODE_RUN; // R3 R6
          end
        end
      end
      pmcr_pkg::MODE_WAKE: begin
        // regulator settles before the cpu clock returns
        if (wake_cnt == 16'h0000) begin
          next_mode = pmcr_pkg::MODE_RUN; // R4
        end else begin
          next_wake_cnt = wake_cnt - 16'h0001;
        end
      end
      default: next_mode = pmcr_pkg::MODE_RUN;
    endcase
    // outputs follow the next mode so they change with it
    next_cpu_en = (next_mode == pmcr_pkg::MODE_RUN); // R8
    next_pmem_en = (next_mode == pmcr_pkg::MODE_RUN); // R8
    next_sys_en = (next_mode == pmcr_pkg::MODE_RUN) ||
                  (next_mode == pmcr_pkg::MODE_IDLE); // R9
    next_clkout = !clock_output_enable_n &&
                  next_sys_en; // R10
    // low-power state in sleep limits usable peripherals
    next_reg_lp = (next_mode == pmcr_pkg::MODE_SLEEP) &&
                  (next_regpm || LOW_VOLTAGE_VARIANT); // R5 R6
  end

  // register the control group
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_src <= pmcr_pkg::RESET_SOURCE;
      req_div <= pmcr_pkg::RESET_DIVIDER;
      idle_select <= pmcr_pkg::RESET_PWR_CTRL[pmcr_pkg::PWR_IDLE_BIT];
      recover_on_interrupt <= pmcr_pkg::RESET_PWR_CTRL[pmcr_pkg::PWR_ROI_BIT];
      doze_enable <= pmcr_pkg::RESET_PWR_CTRL[pmcr_pkg::PWR_DOZE_BIT];
      regulator_power_mode <=
        pmcr_pkg::RESET_PWR_CTRL[pmcr_pkg::PWR_REGPM_BIT];
      active_source <= pmcr_pkg::RESET_SOURCE;
      active_divider <= pmcr_pkg::RESET_DIVIDER;
      switch_busy <= 1'b0;
      mode <= pmcr_pkg::MODE_RUN;
      wake_cnt <= 16'h0000;
      cpu_clock_enable <= 1'b1;
      program_memory_enable <= 1'b1;
      sysclk_periph_enable <= 1'b1;
      intosc_periph_enable <= 1'b1;
      clock_output_active <= 1'b0;
      regulator_low_power <= 1'b0;
      full_speed <= 1'b1;
    end else begin
      req_src <= next_req_src;
      req_div <= next_req_div;
      idle_select <= next_idle_select;
      recover_on_interrupt <= next_roi;
      doze_enable <= next_doze;
      regulator_power_mode <= next_regpm;
      active_source <= next_act_src;
      active_divider <= next_act_div;
      switch_busy <= next_busy;
      mode <= next_mode;
      wake_cnt <= next_wake_cnt;
      cpu_clock_enable <= next_cpu_en;
      program_memory_enable <= next_pmem_en;
      sysclk_periph_enable <= next_sys_en;
      intosc_periph_enable <= 1'b1; // R9
      clock_output_active <= next_clkout;
      regulator_low_power <= next_reg_lp;
      full_speed <= !next_doze; // R12
    end
  end

  // ************************************************************
  // ahb-lite slave, zero wait, always okay
  // ************************************************************
  // read data built from next values so a write just before is seen
  always_comb begin
    next_wr_pend = 1'b0;
    next_wr_idx = wr_idx;
    next_hrdata = 32'h0000_0000;
    if (hsel && hready && (htrans == pmcr_pkg::HTRANS_NONSEQ)) begin
      next_wr_pend = hwrite;
      next_wr_idx = haddr[15:2];
      if (!hwrite) begin
        if (addr_hit(haddr, pmcr_pkg::IDX_OSC_REQ)) begin
          next_hrdata[pmcr_pkg::SRC_MSB:pmcr_pkg::SRC_LSB] = next_req_src;
          next_hrdata[pmcr_pkg::DIV_MSB:pmcr_pkg::DIV_LSB] = next_req_div;
        end else if (addr_hit(haddr, pmcr_pkg::IDX_PWR_CTRL)) begin
          next_hrdata[pmcr_pkg::PWR_IDLE_BIT] = next_idle_select;
          next_hrdata[pmcr_pkg::PWR_ROI_BIT] = next_roi;
          next_hrdata[pmcr_pkg::PWR_DOZE_BIT] = next_doze;
          next_hrdata[pmcr_pkg::PWR_REGPM_BIT] = next_regpm;
        end else if (addr_hit(haddr, pmcr_pkg::IDX_STATUS)) begin
          next_hrdata[pmcr_pkg::SRC_MSB:pmcr_pkg::SRC_LSB] = next_act_src;
          next_hrdata[pmcr_pkg::DIV_MSB:pmcr_pkg::DIV_LSB] = next_act_div;
          next_hrdata[pmcr_pkg::STAT_BUSY_BIT] = next_busy;
          next_hrdata[pmcr_pkg::STAT_MODE_LSB +: 2] = next_mode;
        end
      end
      // high address bits set: decode to nothing, write dropped
      if (haddr[31:16] != 16'h0000) begin
        next_wr_pend = 1'b0;
      end
    end
  end

  // register the bus group
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 14'h0000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_idx <= next_wr_idx;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- verif/pmcr_osc_model.sv
// oscillator side model: ready flags that follow enables after a delay
// assumes the bench drives want from hclk logic
`timescale 1ns/10ps
`default_nettype none

module pmcr_osc_model #(
  parameter int DELAY = 3
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // oscillators that the bench switches on
  input wire logic [pmcr_pkg::RDY_WIDTH-1:0] want,
  // ready flags to the block
  output logic [pmcr_pkg::RDY_WIDTH-1:0] osc_ready
);
  // ************************************************************
  // start-up delay line
  // ************************************************************
  logic [pmcr_pkg::RDY_WIDTH-1:0] pipe [DELAY];

  // a flag drops at once when its oscillator stops, no kindness
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < DELAY; i++) pipe[i] <= '0;
    end else begin
      pipe[0] <= want;
      for (int i = 1; i < DELAY; i++) pipe[i] <= pipe[i-1];
    end
  end
  assign osc_ready = pipe[DELAY-1] & want;
endmodule
`default_nettype wire

//--- verif/pmcr_top_props.sv
// concurrent checks on the power-mode and clock-request ports
// assumes one hclk domain and a wake hold of four cycles in sim
`timescale 1ns/10ps
`default_nettype none

module pmcr_top_props #(
  parameter bit LOW_VOLTAGE_VARIANT = 1'b0,
  parameter int WAKE_CYCLES = 4
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // cpu side
  input wire logic sleep_exec,
  input wire logic interrupt_req,
  input wire logic clock_output_enable_n,
  // clock tree and power
  input wire logic cpu_clock_enable,
  input wire logic program_memory_enable,
  input wire logic sysclk_periph_enable,
  input wire logic intosc_periph_enable,
  input wire logic clock_output_active,
  input wire logic regulator_low_power,
  input wire logic [2:0] active_source,
  input wire logic [3:0] active_divider,
  input wire logic switch_busy
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // leaving low-power sleep, then the settling hold
  sequence s_lp_exit;
    !LOW_VOLTAGE_VARIANT && $fell(regulator_low_power);
  endsequence
  sequence s_wake_hold;
    !cpu_clock_enable [*4];
  endsequence

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  a_intosc_running: assert property (intosc_periph_enable)
    else $error("internal osc peripherals stopped");
  a_cpu_pmem_pair: assert property (
    cpu_clock_enable == program_memory_enable)
    else $error("cpu and program memory disagree");
  a_sys_in_run: assert property (
    cpu_clock_enable |-> sysclk_periph_enable)
    else $error("system peripherals off while running");
  a_clkout_idle: assert property (
    sysclk_periph_enable && !clock_output_enable_n && $past(hresetn)
    && !$past(clock_output_enable_n) |-> clock_output_active)
    else $error("clock output stopped while clocks run");
  a_lp_sleep_only: assert property (
    regulator_low_power |-> !sysclk_periph_enable && !cpu_clock_enable)
    else $error("low-power regulator outside sleep");
  a_lp_wake: assert property (
    regulator_low_power && interrupt_req |=> !regulator_low_power)
    else $error("interrupt did not end low-power sleep");
  a_wake_delay: assert property (
    s_lp_exit |-> s_wake_hold ##1 cpu_clock_enable)
    else $error("wake hold length wrong");
  a_sleep_enter: assert property (
    sleep_exec && cpu_clock_enable |=> !cpu_clock_enable)
    else $error("sleep instruction did not stop cpu");
  a_idle_wake: assert property (
    interrupt_req && sysclk_periph_enable && !cpu_clock_enable
    |=> cpu_clock_enable)
    else $error("interrupt did not end idle");
  a_switch_gated: assert property (
    !$stable(active_source) || !$stable(active_divider)
    |-> $past(switch_busy))
    else $error("clock changed without pending switch");
endmodule

bind pmcr_top pmcr_top_props #(
  .LOW_VOLTAGE_VARIANT(LOW_VOLTAGE_VARIANT), .WAKE_CYCLES(WAKE_CYCLES)
) u_props (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .sleep_exec(sleep_exec), .interrupt_req(interrupt_req),
  .clock_output_enable_n(clock_output_enable_n),
  .cpu_clock_enable(cpu_clock_enable),
  .program_memory_enable(program_memory_enable),
  .sysclk_periph_enable(sysclk_periph_enable),
  .intosc_periph_enable(intosc_periph_enable),
  .clock_output_active(clock_output_active),
  .regulator_low_power(regulator_low_power),
  .active_source(active_source), .active_divider(active_divider),
  .switch_busy(switch_busy)
);
`default_nettype wire

//--- verif/test_power_mode_clock_request.sv
// bench for the power-mode and clock-request block over ahb-lite
// assumes the oscillator model of this folder and a wake hold of 4
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("mismatch at %0t got %h expected %h", $time, a, b); end end

module test_power_mode_clock_request;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
  logic sleep_exec = 0, interrupt_req = 0, clock_output_enable_n = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2, active_source, src;
  logic [3:0] active_divider, div;
  logic [4:0] want = 5'h1F, osc_ready;
  logic hreadyout, hresp, cpu_clock_enable, program_memory_enable;
  logic sysclk_periph_enable, intosc_periph_enable, clock_output_active;
  logic regulator_low_power, full_speed, switch_busy;
  logic lv_cpu, lv_reg_lp;
  logic [2:0] srcs [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1};
  int failures = 0, cmp_count = 0;
  localparam logic [13:0] REQ = pmcr_pkg::IDX_OSC_REQ;
  localparam logic [13:0] PWR = pmcr_pkg::IDX_PWR_CTRL;
  localparam logic [13:0] STS = pmcr_pkg::IDX_STATUS;

  always #5 hclk = ~hclk;
  assign hready = hreadyout;

  pmcr_top #(.WAKE_CYCLES(4)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sleep_exec(sleep_exec),
    .interrupt_req(interrupt_req),
    .clock_output_enable_n(clock_output_enable_n), .osc_ready(osc_ready),
    .cpu_clock_enable(cpu_clock_enable),
    .program_memory_enable(program_memory_enable),
    .sysclk_periph_enable(sysclk_periph_enable),
    .intosc_periph_enable(intosc_periph_enable),
    .clock_output_active(clock_output_active),
    .regulator_low_power(regulator_low_power), .full_speed(full_speed),
    .active_source(active_source), .active_divider(active_divider),
    .switch_busy(switch_busy));

  // low-voltage variant on the same bus, only its mode outputs watched
  pmcr_top #(.LOW_VOLTAGE_VARIANT(1'b1), .WAKE_CYCLES(4)) uut_lv (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(), .hresp(), .hrdata(),
    .sleep_exec(sleep_exec), .interrupt_req(interrupt_req),
    .clock_output_enable_n(clock_output_enable_n), .osc_ready(osc_ready),
    .cpu_clock_enable(lv_cpu), .program_memory_enable(),
    .sysclk_periph_enable(), .intosc_periph_enable(),
    .clock_output_active(), .regulator_low_power(lv_reg_lp),
    .full_speed(), .active_source(), .active_divider(), .switch_busy());

  pmcr_osc_model u_osc (.hclk(hclk), .hresetn(hresetn), .want(want),
    .osc_ready(osc_ready));

  // ************************************************************
  // bus and cpu tasks
  // ************************************************************
  // one single transfer, address phase then data phase
  task automatic bus(input logic w, input logic [13:0] idx,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {16'h0, idx, 2'b00};
    hwrite <= w; htrans <= pmcr_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [13:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rchk(input logic [13:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    `CHK(rd, e)
  endtask
  // bounded wait for a pending switch to finish
  task automatic wait_sw();
    @(negedge hclk);
    for (int i = 0; i < 60 && switch_busy !== 1'b0; i++) @(negedge hclk);
    `CHK(switch_busy, 1'b0)
  endtask
  // one-cycle strobe from the cpu side, outputs looked at after
  task automatic strobe(input bit is_irq);
    @(posedge hclk);
    if (is_irq) interrupt_req <= 1'b1; else sleep_exec <= 1'b1;
    @(posedge hclk);
    interrupt_req <= 1'b0; sleep_exec <= 1'b0;
    @(negedge hclk);
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // watchdog, far beyond the expected run of about 120 cycles
  initial begin
    #200000;
    failures++;
    end_sim();
  end

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(REQ, 32'h62);
    `CHK(active_source, pmcr_pkg::RESET_SOURCE)
    `CHK(full_speed, 1'b1)
    done("reset");
    // every valid source, divider ends 2 and 9 included
    for (int i = 0; i < 6; i++) begin
      src = srcs[i];
      div = 4'(2 + i + 2 * (i / 5));
      wr(REQ, 32'({src, div}));
      wait_sw();
      `CHK(active_source, src)
      `CHK(active_divider, div)
    end
    // reserved codes start no switch
    for (int i = 0; i < 4; i++) begin
      wr(REQ, i < 2 ? 32'(i * 48 + 2) : (i == 2 ? 32'h6A : 32'h6F));
      @(negedge hclk);
      `CHK(switch_busy, 1'b0)
      `CHK(active_divider, 4'h9)
    end
    rchk(REQ, 32'h6F);
    done("codes");
    // switch waits for the new oscillator
    want <= 5'h1E;
    // let the lost ready pass the synchroniser before the request
    repeat (6) @(negedge hclk);
    wr(REQ, 32'h73);
    repeat (10) @(negedge hclk);
    `CHK(switch_busy, 1'b1)
    `CHK(active_source, 3'h1)
    want <= 5'h1F;
    wait_sw();
    `CHK(active_source, 3'h7)
    done("switch");
    rchk(14'h0100, 32'h0);
    wr(14'h0100, 32'hFF);
    rchk(14'h0100, 32'h0);
    rchk(STS, 32'h73);
    wr(STS, 32'h0);
    rchk(STS, 32'h73);
    done("map");
    // idle with recover and doze
    wr(PWR, 32'h7);
    @(negedge hclk);
    `CHK(full_speed, 1'b0)
    strobe(0);
    `CHK(cpu_clock_enable, 1'b0)
    `CHK(program_memory_enable, 1'b0)
    `CHK(sysclk_periph_enable, 1'b1)
    `CHK(clock_output_active, 1'b1)
    strobe(1);
    `CHK(cpu_clock_enable, 1'b1)
    `CHK(full_speed, 1'b1)
    rchk(PWR, 32'h3);
    strobe(0);
    `CHK(cpu_clock_enable, 1'b0)
    strobe(1);
    done("idle");
    // normal sleep then low-power sleep
    wr(PWR, 32'h0);
    strobe(0);
    `CHK(sysclk_periph_enable, 1'b0)
    `CHK(intosc_periph_enable, 1'b1)
    `CHK(regulator_low_power, 1'b0)
    `CHK(lv_reg_lp, 1'b1)
    strobe(1);
    `CHK(cpu_clock_enable, 1'b1)
    `CHK(lv_cpu, 1'b1)
    wr(PWR, 32'h8);
    strobe(0);
    `CHK(regulator_low_power, 1'b1)
    strobe(1);
    `CHK(cpu_clock_enable, 1'b0)
    `CHK(lv_cpu, 1'b1)
    `CHK(regulator_low_power, 1'b0)
    repeat (3) @(negedge hclk);
    `CHK(cpu_clock_enable, 1'b0)
    @(negedge hclk);
    `CHK(cpu_clock_enable, 1'b1)
    done("sleep");
    end_sim();
  end
endmodule
`default_nettype wire
